// ===== core/apc_pkg.sv
// Shared types and constants of the converter pin control logic.
// Assumes one clock domain on mclk; pins arrive unsynchronised.
`default_nettype none

package apc_pkg;

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 8;
  localparam logic [2:0]  BIT_FIRST  = 3'h0;
  localparam logic [2:0]  BIT_LAST   = 3'h7;

  // ----------------------------------------------------------------
  // Port and mode register
  // ----------------------------------------------------------------
  // Direction bits: 1 makes the pin an input
  typedef struct packed {
    logic syncEnable;
    logic gpioBDirection;
    logic gpioBValue;
    logic gpioADirection;
    logic gpioAValue;
  } apc_port_t;

  localparam apc_port_t PORT_RESET = '{
    syncEnable:     1'b0,
    gpioBDirection: 1'b1,
    gpioBValue:     1'b0,
    gpioADirection: 1'b0,
    gpioAValue:     1'b0
  };
  localparam logic CLOCK_OUTPUT_DISABLE_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Sampled pins
  // ----------------------------------------------------------------
  typedef struct packed {
    logic resetN;
    logic csN;
    logic sclk;
    logic din;
    logic gpioB;
  } apc_pins_t;

  localparam apc_pins_t PINS_IDLE = '{
    resetN: 1'b1,
    csN:    1'b1,
    sclk:   1'b1,
    din:    1'b0,
    gpioB:  1'b1
  };

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  typedef struct packed {
    apc_port_t  port;
    logic       clock_output_disable;
    logic       sclkPrev;
    logic [2:0] bitCnt;
    logic [7:0] shIn;
    logic [7:0] shOut;
    logic [7:0] rxByte;
    logic       rxValid;
    logic       txLoad;
    logic       dout;
    logic       doutOe;
    logic       syncN;
    logic       syncStart;
    logic       gpioBRead;
    logic       devRst;
  } apc_state_t;

  localparam apc_state_t STATE_RESET = '{
    port:      PORT_RESET,
    clock_output_disable:    CLOCK_OUTPUT_DISABLE_RESET,
    sclkPrev:  1'b1,
    bitCnt:    BIT_FIRST,
    shIn:      8'h00,
    shOut:     8'h00,
    rxByte:    8'h00,
    rxValid:   1'b0,
    txLoad:    1'b0,
    dout:      1'b0,
    doutOe:    1'b0,
    syncN:     1'b1,
    syncStart: 1'b0,
    gpioBRead: 1'b0,
    devRst:    1'b1
  };

endpackage

`default_nettype wire

// ===== core/apc_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs asynchronous to clk; reset is synchronous.
`default_nettype none

module apc_sync #(
  parameter int unsigned         WIDTH = 1,
  parameter logic [WIDTH-1:0]    INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } apc_sync_st_t;

  localparam apc_sync_st_t SYNC_RESET = '{INIT, INIT, INIT, INIT};

  apc_sync_st_t st_r;
  apc_sync_st_t st_nxt;
  logic [WIDTH-1:0] agree;

  // ----------------------------------------------------------------
  // Stage chain; output moves only when stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    agree      = ~(st_r.s2 ^ st_r.s3);
    st_nxt     = st_r;
    st_nxt.s1  = d;
    st_nxt.s2  = st_r.s1;
    st_nxt.s3  = st_r.s2;
    st_nxt.q   = (agree & st_r.s3) | (~agree & st_r.q);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= SYNC_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;

endmodule

`default_nettype wire

// ===== core/apc_pin_ctrl.sv
// Pin-level control of the converter: serial framing, pin reset,
// master clock output, and the two dual-purpose port pins.
// Assumes a serial master on the pins and port/mode writes on mclk.
`default_nettype none

module apc_pin_ctrl (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              masterClockInput,
  output logic                   masterClockOutput,
  input  wire logic              sclkPin,
  input  wire logic              csNPin,
  input  wire logic              dinPin,
  input  wire logic              resetNPin,
  output logic                   doutOut,
  output logic                   doutOe,
  output logic                   analogCommonGpioAOut,
  output logic                   analogCommonGpioAOe,
  output logic                   analogCommonSelect,
  input  wire logic              syncGpioBIn,
  output logic                   syncGpioBOut,
  output logic                   syncGpioBOe,
  input  wire logic              portWrite,
  input  wire apc_pkg::apc_port_t portWriteData,
  output apc_pkg::apc_port_t     portState,
  output logic                   gpioBReadValue,
  input  wire logic              modeWrite,
  input  wire logic              clockOutputDisableIn,
  output logic                   clockOutputDisable,
  input  wire logic [7:0]        txByte,
  output logic                   txLoad,
  output logic [7:0]             rxByte,
  output logic                   rxValid,
  output logic                   filterSyncN,
  output logic                   syncStart,
  output logic                   deviceReset
);

  apc_pkg::apc_state_t st_r;
  apc_pkg::apc_state_t st_nxt;
  apc_pkg::apc_pins_t  pinsRaw;
  apc_pkg::apc_pins_t  pins;
  logic                anyRst;
  logic                sclkRise;
  logic                sclkFall;
  logic                bIsInput;
  logic                syncLevel;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  assign pinsRaw = '{
    resetN: resetNPin,
    csN:    csNPin,
    sclk:   sclkPin,
    din:    dinPin,
    gpioB:  syncGpioBIn
  };

  apc_sync #(
    .WIDTH ($bits(apc_pkg::apc_pins_t)),
    .INIT  (apc_pkg::PINS_IDLE)
  ) u_pinSync (
    .clk (mclk),
    .rst (reset),
    .d   (pinsRaw),
    .q   (pins)
  );

  assign anyRst   = reset | ~pins.resetN;
  assign sclkRise = pins.sclk & ~st_r.sclkPrev;
  assign sclkFall = ~pins.sclk & st_r.sclkPrev;
  assign bIsInput = st_r.port.gpioBDirection | st_r.port.syncEnable;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.rxValid   = 1'b0;
    st_nxt.txLoad    = 1'b0;
    st_nxt.syncStart = 1'b0;
    st_nxt.devRst    = 1'b0;
    st_nxt.sclkPrev  = pins.sclk;
    if (portWrite) begin
      st_nxt.port = portWriteData;
    end
    if (modeWrite) begin
      st_nxt.clock_output_disable = clockOutputDisableIn;
    end
    if (pins.csN) begin
      st_nxt.bitCnt = apc_pkg::BIT_FIRST;
      st_nxt.doutOe = 1'b0;
    end else begin
      st_nxt.doutOe = 1'b1;
      if (sclkFall) begin
        if (st_r.bitCnt == apc_pkg::BIT_FIRST) begin
          st_nxt.dout   = txByte[7];
          st_nxt.shOut  = {txByte[6:0], 1'b0};
          st_nxt.txLoad = 1'b1;
        end else begin
          st_nxt.dout  = st_r.shOut[7];
          st_nxt.shOut = {st_r.shOut[6:0], 1'b0};
        end
      end
      if (sclkRise) begin
        st_nxt.shIn   = {st_r.shIn[6:0], pins.din};
        st_nxt.bitCnt = st_r.bitCnt + 3'h1;
        if (st_r.bitCnt == apc_pkg::BIT_LAST) begin
          st_nxt.rxByte  = {st_r.shIn[6:0], pins.din};
          st_nxt.rxValid = 1'b1;
        end
      end
    end
    // Pin B level is assumed driven while it is an input
    syncLevel        = st_r.port.syncEnable ? pins.gpioB : 1'b1;
    st_nxt.syncN     = syncLevel;
    st_nxt.syncStart = st_r.syncN & ~syncLevel;
    st_nxt.gpioBRead = bIsInput ? pins.gpioB
                                : st_r.port.gpioBValue;
  end

  always_ff @(posedge mclk) begin
    if (anyRst) begin
      st_r <= apc_pkg::STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Inverted clock copy is combinational so it keeps the input's edge timing
  assign masterClockOutput    = ~st_r.clock_output_disable & ~masterClockInput;
  assign doutOut              = st_r.dout;
  assign doutOe               = st_r.doutOe;
  assign analogCommonGpioAOut = st_r.port.gpioAValue;
  assign analogCommonGpioAOe  = ~st_r.port.gpioADirection;
  assign analogCommonSelect   = st_r.port.gpioADirection;
  assign syncGpioBOut         = st_r.port.gpioBValue;
  assign syncGpioBOe          = ~bIsInput;
  assign portState            = st_r.port;
  assign gpioBReadValue       = st_r.gpioBRead;
  assign clockOutputDisable   = st_r.clock_output_disable;
  assign txLoad               = st_r.txLoad;
  assign rxByte               = st_r.rxByte;
  assign rxValid              = st_r.rxValid;
  assign filterSyncN          = st_r.syncN;
  assign syncStart            = st_r.syncStart;
  assign deviceReset          = st_r.devRst;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_clkOut;
    st_r.clock_output_disable |-> !masterClockOutput;
  endproperty
  a_clkOut: assert property (p_clkOut)
    else $error("clock output active while disabled");

  property p_clkInv;
    !st_r.clock_output_disable |-> masterClockOutput != masterClockInput;
  endproperty
  a_clkInv: assert property (p_clkInv)
    else $error("clock output not inverted copy");

  property p_pinA;
    (analogCommonGpioAOe == !analogCommonSelect) &&
    (!analogCommonGpioAOe || analogCommonGpioAOut == portState.gpioAValue);
  endproperty
  a_pinA: assert property (p_pinA)
    else $error("pin A drive does not follow port bits");

  property p_pinB;
    portWrite && !portWriteData.gpioBDirection &&
    !portWriteData.syncEnable && pins.resetN
    |=> syncGpioBOe && syncGpioBOut == $past(portWriteData.gpioBValue);
  endproperty
  a_pinB: assert property (p_pinB)
    else $error("pin B not driven after output write");

  property p_syncIn;
    portState.syncEnable |-> !syncGpioBOe;
  endproperty
  a_syncIn: assert property (p_syncIn)
    else $error("pin B driven while sync enabled");

  property p_csIdle;
    pins.csN && pins.resetN |=> !doutOe && st_r.bitCnt == 3'h0 && !rxValid;
  endproperty
  a_csIdle: assert property (p_csIdle)
    else $error("bus activity while deselected");

  property p_frame;
    rxValid |-> $past(st_r.bitCnt) == 3'h7 && $past(sclkRise);
  endproperty
  a_frame: assert property (p_frame)
    else $error("byte completed off the eighth edge");

  property p_count;
    !pins.csN && sclkRise && pins.resetN
    |=> st_r.bitCnt == $past(st_r.bitCnt) + 3'h1;
  endproperty
  a_count: assert property (p_count)
    else $error("bit count did not advance");

  property p_pinReset;
    !pins.resetN |=> portState == apc_pkg::PORT_RESET && deviceReset
                     && !clockOutputDisable;
  endproperty
  a_pinReset: assert property (p_pinReset)
    else $error("pin reset did not restore defaults");

  c_byte:  cover property (rxValid);
  c_sync:  cover property (syncStart);
  c_3wire: cover property (!pins.csN [*8] ##1 txLoad);
  c_reset: cover property (!pins.resetN ##1 pins.resetN);

endmodule

`default_nettype wire

// ===== dv/apc_host.sv
// Host serial master model for the pin control bench.
// Assumes calls start just after an mclk edge; serial clock 80 ns.
`default_nettype none

module apc_host (
  output logic      sclk,
  output logic      csN,
  output logic      din,
  input  wire logic dout
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk = 1'b1;
    csN  = 1'b1;
    din  = 1'b0;
  end

  task automatic sel(input logic on);
    csN = !on;
  endtask

  // Mode 3: new bit on fall, capture on rise; clock still between frames
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sclk  = 1'b0;
      din   = tx[i];
      #40;
      sclk  = 1'b1;
      rx[i] = dout;
      #40;
    end
    din = !din; // Released line
    #40;
  endtask
endmodule

`default_nettype wire

// ===== dv/tb_apc_pin_ctrl.sv
// Self-checking bench of the converter pin control logic.
// Assumes apc_pkg, apc_pin_ctrl and apc_host are compiled first.
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
  err_count++; $display("unexpected at %0t got %0h exp %0h", \
  $time, (a), (b)); end end

module tb_apc_pin_ctrl;
  timeunit 1ns;
  timeprecision 1ps;

  logic               mclk = 1'b0;
  logic               reset = 1'b1;
  logic               mci = 1'b0;
  logic               resetN = 1'b1;
  logic               gB = 1'b1;
  logic               portWrite = 1'b0;
  apc_pkg::apc_port_t portWriteData = '0;
  logic               modeWrite = 1'b0;
  logic               clkDisIn = 1'b0;
  logic [7:0]         txByte = 8'h00;
  logic [7:0]         hostRx, rxLast, rxByte;
  logic               sclk, csN, din, doutOut, doutOe, rxValid;
  logic               aOut, aOe, aSel, bOut, bOe, gpioBReadValue;
  logic               mco, clock_output_disable, txLoad, filterSyncN, syncStart;
  logic               deviceReset;
  apc_pkg::apc_port_t portState, v;
  int                 err_count = 0, cmp_count = 0, rxCnt = 0;
  int                 syncCnt = 0, txCnt = 0, k;

  always #2 mclk = ~mclk;

  apc_pin_ctrl dut (
    .mclk(mclk), .reset(reset), .masterClockInput(mci),
    .masterClockOutput(mco), .sclkPin(sclk), .csNPin(csN),
    .dinPin(din), .resetNPin(resetN), .doutOut(doutOut),
    .doutOe(doutOe), .analogCommonGpioAOut(aOut),
    .analogCommonGpioAOe(aOe), .analogCommonSelect(aSel),
    .syncGpioBIn(gB), .syncGpioBOut(bOut), .syncGpioBOe(bOe),
    .portWrite(portWrite), .portWriteData(portWriteData),
    .portState(portState), .gpioBReadValue(gpioBReadValue),
    .modeWrite(modeWrite), .clockOutputDisableIn(clkDisIn),
    .clockOutputDisable(clock_output_disable), .txByte(txByte), .txLoad(txLoad),
    .rxByte(rxByte), .rxValid(rxValid), .filterSyncN(filterSyncN),
    .syncStart(syncStart), .deviceReset(deviceReset)
  );

  // Released data line shows the inverse of the last driven bit
  apc_host host (.sclk(sclk), .csN(csN), .din(din),
                 .dout(doutOe ? doutOut : !doutOut));

  // Pulse counters, sampled where outputs are settled
  always @(negedge mclk) begin
    if (rxValid === 1'b1) begin
      rxCnt++;
      rxLast = rxByte;
    end
    if (syncStart === 1'b1) syncCnt++;
    if (txLoad === 1'b1) txCnt++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr_port(input apc_pkg::apc_port_t d);
    portWrite = 1'b1;
    portWriteData = d;
    tick(1);
    portWrite = 1'b0;
    tick(1);
  endtask

  task automatic wr_mode(input logic d);
    modeWrite = 1'b1;
    clkDisIn = d;
    tick(1);
    modeWrite = 1'b0;
    tick(1);
  endtask

  task automatic send(input logic [7:0] h, d, input int n);
    txByte = d;
    host.xfer(h, n, hostRx);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Whole-run limit
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end

  initial begin
    tick(8);
    `CHK(portState, apc_pkg::PORT_RESET)
    `CHK({deviceReset, filterSyncN, doutOe, clock_output_disable}, 4'hC)
    reset = 1'b0;
    tick(3);
    for (int i = 0; i < 32; i++) begin
      v = apc_pkg::apc_port_t'(5'(i));
      wr_port(v);
      `CHK(portState, v)
      `CHK({aOe, aOut}, {!v.gpioADirection, v.gpioAValue})
      `CHK(aSel, v.gpioADirection)
      `CHK({bOe, bOut}, {!(v.gpioBDirection | v.syncEnable),
                         v.gpioBValue})
    end
    wr_port(apc_pkg::PORT_RESET);
    gB = 1'b0;
    tick(8);
    `CHK(gpioBReadValue, 1'b0)
    gB = 1'b1;
    tick(8);
    `CHK(gpioBReadValue, 1'b1)
    wr_port(apc_pkg::apc_port_t'(5'h04));
    gB = 1'b0;
    tick(8);
    `CHK(gpioBReadValue, 1'b1)
    `CHK({syncCnt, filterSyncN}, {32'h0, 1'b1})
    gB = 1'b1;
    tick(8);
    wr_port(apc_pkg::apc_port_t'(5'h18));
    tick(8);
    gB = 1'b0;
    for (k = 0; k < 16 && filterSyncN !== 1'b0; k++) tick(1);
    if (k == 16) begin
      err_count++;
      wrap_up();
    end
    tick(2);
    `CHK(syncCnt, 1)
    gB = 1'b1;
    tick(8);
    `CHK(filterSyncN, 1'b1)
    for (int i = 0; i < 4; i++) begin
      mci = i[0];
      tick(1);
      `CHK(mco, !mci)
    end
    wr_mode(1'b1);
    `CHK(clock_output_disable, 1'b1)
    mci = 1'b0;
    tick(1);
    `CHK(mco, 1'b0)
    host.sel(1'b1);
    tick(8);
    `CHK(doutOe, 1'b1)
    send(8'hA5, 8'h3C, 8);
    `CHK({hostRx, rxLast}, 16'h3CA5)
    send(8'hC3, 8'h96, 8);
    `CHK({hostRx, rxLast, 8'(rxCnt)}, 24'h96C302)
    `CHK(txCnt, 2)
    send(8'hFF, 8'h00, 4);
    host.sel(1'b0);
    tick(8);
    `CHK(doutOe, 1'b0)
    host.sel(1'b1);
    tick(8);
    send(8'h5A, 8'h81, 8);
    `CHK({hostRx, rxLast, 8'(rxCnt)}, 24'h815A03)
    host.sel(1'b0);
    tick(8);
    send(8'h99, 8'h00, 8);
    `CHK(rxCnt, 3)
    `CHK(txCnt, 4)
    wr_port(apc_pkg::apc_port_t'(5'h07));
    resetN = 1'b0;
    tick(8);
    `CHK({portState, clock_output_disable, deviceReset},
         {apc_pkg::PORT_RESET, 2'h1})
    resetN = 1'b1;
    tick(8);
    `CHK(deviceReset, 1'b0)
    wrap_up();
  end
endmodule

`default_nettype wire
